// [otg_map.svh]
/*
 * Register offsets, field positions, reset values, voltage decode
 * constants and timing counts of the VBUS switch and voltage-code block.
 * Assumes a single 50 MHz clock and an 8-bit register port.
 */
`ifndef OTG_MAP_SVH
`define OTG_MAP_SVH

// ==========================================================
// Register offsets (8-bit register port)
// ==========================================================
`define OTG_REG_CTRL 8'h00
`define OTG_REG_IRQ_EN 8'h01
`define OTG_REG_STATUS 8'h02
`define OTG_REG_BOOST_CODE 8'h03
`define OTG_REG_BUCK_CODE0 8'h04
`define OTG_REG_LDO_CODE0 8'h07

// ==========================================================
// Field positions and reset values
// ==========================================================
`define OTG_BIT_BOOST_PATH 0
`define OTG_BIT_INPUT_PATH 1
`define OTG_BIT_STAT_SW_BOOST 4
`define OTG_BIT_STAT_SW_INPUT 5
`define OTG_BIT_STAT_OVP 6
`define OTG_RST_CTRL 2'h0
`define OTG_RST_IRQ_EN 2'h0
`define OTG_RST_BOOST_CODE 8'h54
`define OTG_RST_BUCK_CODE 6'h18
`define OTG_RST_LDO_CODE 6'h18

// ==========================================================
// Six-bit code decode, millivolts
// ==========================================================
`define OTG_V6_LO_BASE 12'h258
`define OTG_V6_LO_RSTEP 12'h0c8
`define OTG_V6_LO_STEP 12'h019
`define OTG_V6_MID_BASE 12'h4b0
`define OTG_V6_MID_RSTEP 12'h190
`define OTG_V6_MID_STEP 12'h032
`define OTG_V6_HI_BASE 12'h960
`define OTG_V6_HI_RSTEP 12'h320
`define OTG_V6_HI_STEP 12'h064

// ==========================================================
// Eight-bit step-up code decode, millivolts
// ==========================================================
`define OTG_V8_FLOOR 16'h0bb8
`define OTG_V8_R3_BASE 16'h1838
`define OTG_V8_R4_BASE 16'h24b8
`define OTG_V8_R5_BASE 16'h3138
`define OTG_V8_R6_BASE 16'h4a38
`define OTG_V8_R7_BASE 16'h7c38
`define OTG_V8_SAT 16'ha1b8
`define OTG_V8_SAT_STEP 5'h18
`define OTG_V8_STEP_S 16'h0064
`define OTG_V8_STEP_M 16'h00c8
`define OTG_V8_STEP_L 16'h0190

// ==========================================================
// Timing
// ==========================================================
`define OTG_CLK_KHZ 50000
`define OTG_TICK_MS 1
`define OTG_TICK_CYCLES (`OTG_TICK_MS * `OTG_CLK_KHZ)
`define OTG_OC_TIMEOUT_MS 256
`define OTG_OC_TICKS 9'h100

`endif

// [otg_pkg.sv]
/*
 * Types of the VBUS switch and voltage-code block.
 * Assumes otg_map.svh supplies all numbers.
 */
package otg_pkg;

    // ==========================================================
    // Carriers
    // ==========================================================
    // Comparator and detector levels from the analog side
    typedef struct packed {
        logic charger_ovp; // Charger input above 6 V
        logic input_oc; // Input path current above limit
        logic boost_oc; // Boost path current above limit
    } otg_sense_s;

    typedef logic [2:0][11:0] otg_buck_mv_t;
    typedef logic [3:0][11:0] otg_ldo_mv_t;

    // ==========================================================
    // State records
    // ==========================================================
    typedef struct packed {
        logic [8:0] cnt; // Whole ticks spent over the limit
        logic trip; // One-cycle turn-off request
    } otg_tmr_s;

    typedef struct packed {
        otg_sense_s sense_m; // First synchroniser stage
        otg_sense_s sense_q; // Second synchroniser stage
        logic [15:0] tick_cnt; // Millisecond divider
        logic tick; // One-cycle millisecond enable
        logic [1:0] ctrl; // Switch-on control bits
        logic [1:0] irq_en; // Fault interrupt enables
        logic [1:0] status; // Sticky over-current faults
        logic [1:0] lock; // Held off after a trip
        logic [1:0] sw; // Switch drive
        logic [7:0] boost_code; // Step-up voltage code
        logic [2:0][5:0] buck_code; // Step-down voltage codes
        logic [3:0][5:0] ldo_code; // Linear regulator codes
        logic [7:0] rdata; // Read data
        otg_buck_mv_t buck_mv; // Decoded step-down targets
        otg_ldo_mv_t ldo_mv; // Decoded linear targets
        logic [15:0] boost_mv; // Decoded step-up target
    } otg_top_s;

endpackage

// [otg_oc_timer.sv]
/*
 * Over-current persistence timer for one VBUS switch.
 * Assumes over is already synchronised and tick is a one-cycle
 * millisecond enable on the same clock.
 */
`timescale 1ns/1ps
`include "otg_map.svh"

module otg_oc_timer (
    input wire logic sys_clk, // 50 MHz clock
    input wire logic srst, // Synchronous reset, high
    input wire logic tick, // Millisecond enable
    input wire logic over, // Switch on and over limit
    output logic trip // Turn-off pulse
);
    import otg_pkg::*;

    otg_tmr_s s; // Registered state
    otg_tmr_s next_s; // Next state

    // ==========================================================
    // Counting
    // ==========================================================
    // Trip only on the tick after the limit count, so the overload has
    // lasted strictly longer than the timeout whatever the tick phase
    always_comb begin
        next_s = s;
        next_s.trip = 1'b0;
        if (!over) begin
            next_s.cnt = 9'h000; // R16
        end else if (tick) begin
            if (s.cnt == `OTG_OC_TICKS) begin
                next_s.trip = 1'b1; // R7 R11
                next_s.cnt = 9'h000;
            end else begin
                next_s.cnt = s.cnt + 9'h001;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign trip = s.trip;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_timer_restart: assert property (!over |=> s.cnt == 9'h000) // R16
        else $error("over-current timer kept counting after recovery");
    a_trip_count: assert property (trip |-> $past(over) &&
        $past(s.cnt) == `OTG_OC_TICKS) // R7
        else $error("trip without a full over-current count");
endmodule

// [otg_switch_ctrl.sv]
/*
 * VBUS power-path switch control and regulator voltage-code decode.
 * Assumes the analog comparators arrive asynchronously and the host
 * drives the register port on sys_clk.
 */
// Implementation choices: the strobed register port and the register offsets.
// How it works
// R1: step-down code: range bits select step size
// R2: linear codes decode like step-down codes
// R3: step-up ranges 000, 001 give 3.000 V
// R4: step-up ranges 010-100 add 0.1 V steps
// R5: ranges 101-111 larger steps, saturate 41.4 V
// R6: boost path switch follows its on bit
// R7: boost overload over 256 ms trips off
// R8: tripped boost switch needs 0-to-1 re-arm
// R9: boost fault interrupt only when enabled
// R10: input switch off while boost switch on
// R11: input overload over 256 ms trips off
// R12: tripped input switch needs 0-to-1 re-arm
// R13: charger over-voltage forces input switch off
// R14: input fault interrupt only when enabled
// R15: host rewrites voltage codes to retarget
// R16: overload timer restarts when current recovers
`timescale 1ns/1ps
`include "otg_map.svh"

module otg_switch_ctrl #(
    parameter int MS_CYCLES = `OTG_TICK_CYCLES // Clocks per millisecond
) (
    input wire logic sys_clk, // 50 MHz clock
    input wire logic srst, // Synchronous reset, high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire otg_pkg::otg_sense_s sense, // Asynchronous detectors
    output logic boost_path_switch, // Boost to VBUS switch drive
    output logic input_path_switch, // Charger to VBUS switch drive
    output logic irq, // Level interrupt, high
    output otg_pkg::otg_buck_mv_t buck_mv, // Step-down targets, mV
    output otg_pkg::otg_ldo_mv_t ldo_mv, // Linear targets, mV
    output logic [15:0] boost_mv // Step-up target, mV
);
    import otg_pkg::*;

    otg_top_s s; // Registered state
    otg_top_s next_s; // Next state
    logic [1:0] trip; // Timer turn-off pulses
    logic [1:0] rise; // Re-arm edges on the on bits
    logic [1:0] w1c; // Status bits being cleared
    logic ctrl_wr; // Write to the control register

    // ==========================================================
    // Decode functions
    // ==========================================================
    // Six-bit code: three ranges of 25, 50 and 100 mV steps
    function automatic logic [11:0] dec6(input logic [5:0] code);
        logic [11:0] rr;
        logic [11:0] ss;
        logic [11:0] v;
        rr = {9'h000, code[5:3]};
        ss = {9'h000, code[2:0]};
        if (code[5:3] < 3'h3) begin
            v = `OTG_V6_LO_BASE + rr * `OTG_V6_LO_RSTEP
                + ss * `OTG_V6_LO_STEP;
        end else if (code[5:3] < 3'h6) begin
            v = `OTG_V6_MID_BASE + (rr - 12'h003) * `OTG_V6_MID_RSTEP
                + ss * `OTG_V6_MID_STEP;
        end else begin
            v = `OTG_V6_HI_BASE + (rr - 12'h006) * `OTG_V6_HI_RSTEP
                + ss * `OTG_V6_HI_STEP;
        end
        return v;
    endfunction

    // Eight-bit step-up code; the top range clips at its ceiling
    function automatic logic [15:0] dec8(input logic [7:0] code);
        logic [15:0] ss;
        logic [15:0] v;
        ss = {11'h000, code[4:0]};
        unique case (code[7:5])
            3'h0, 3'h1: begin
                v = `OTG_V8_FLOOR; // R3
            end
            3'h2: begin
                v = `OTG_V8_FLOOR + ss * `OTG_V8_STEP_S; // R4
            end
            3'h3: begin
                v = `OTG_V8_R3_BASE + ss * `OTG_V8_STEP_S; // R4
            end
            3'h4: begin
                v = `OTG_V8_R4_BASE + ss * `OTG_V8_STEP_S; // R4
            end
            3'h5: begin
                v = `OTG_V8_R5_BASE + ss * `OTG_V8_STEP_M; // R5
            end
            3'h6: begin
                v = `OTG_V8_R6_BASE + ss * `OTG_V8_STEP_L; // R5
            end
            3'h7: begin
                // Saturation guards against a target above the rating
                if (code[4:0] >= `OTG_V8_SAT_STEP) begin
                    v = `OTG_V8_SAT; // R5
                end else begin
                    v = `OTG_V8_R7_BASE + ss * `OTG_V8_STEP_L; // R5
                end
            end
        endcase
        return v;
    endfunction

    // ==========================================================
    // Over-current timers, one per switch
    // ==========================================================
    // Only an energised switch can carry overload current, so the
    // comparator is qualified by the switch drive
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            otg_oc_timer u_tmr (
                .sys_clk(sys_clk),
                .srst(srst),
                .tick(s.tick),
                .over(s.sw[gi] & (gi == 0 ? s.sense_q.boost_oc
                                          : s.sense_q.input_oc)),
                .trip(trip[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Write side strobes
    // ==========================================================
    // Re-arm edges are seen at the write, not by sampling the bit,
    // so a clear and set in back-to-back writes is never missed
    always_comb begin
        ctrl_wr = reg_wr && (reg_addr == `OTG_REG_CTRL);
        rise = ctrl_wr ? (reg_wdata[1:0] & ~s.ctrl) : 2'h0;
        w1c = (reg_wr && (reg_addr == `OTG_REG_STATUS)) ? reg_wdata[1:0]
                                                       : 2'h0;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_s = s;
        // Two-flop synchroniser on the analog detectors
        next_s.sense_m = sense;
        next_s.sense_q = s.sense_m;

        // Millisecond enable divider
        next_s.tick = 1'b0;
        if (s.tick_cnt == 16'(MS_CYCLES - 1)) begin
            next_s.tick_cnt = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 16'h0001;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `OTG_REG_CTRL: begin
                    next_s.ctrl = reg_wdata[1:0]; // R6
                end
                `OTG_REG_IRQ_EN: begin
                    next_s.irq_en = reg_wdata[1:0];
                end
                `OTG_REG_BOOST_CODE: begin
                    next_s.boost_code = reg_wdata; // R15
                end
                default: begin
                    // Voltage code banks; anything else is ignored
                    for (int i = 0; i < 3; i++) begin
                        if (reg_addr == `OTG_REG_BUCK_CODE0 + 8'(i)) begin
                            next_s.buck_code[i] = reg_wdata[5:0]; // R15
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr == `OTG_REG_LDO_CODE0 + 8'(i)) begin
                            next_s.ldo_code[i] = reg_wdata[5:0]; // R15
                        end
                    end
                end
            endcase
        end

        // Trip latch and sticky fault; a trip beats a same-cycle
        // re-arm or clear so no fault is ever lost
        next_s.lock = (s.lock & ~rise) | trip; // R8 R12 R7 R11
        next_s.status = (s.status & ~w1c) | trip; // R7 R11

        // Switch drive from the next control state
        next_s.sw[0] = next_s.ctrl[0] & ~next_s.lock[0]; // R6 R8
        next_s.sw[1] = next_s.ctrl[1] & ~next_s.lock[1] // R12
            & ~next_s.sw[0] // R10
            & ~s.sense_q.charger_ovp; // R13

        // Read data stands one cycle after the strobe only
        next_s.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `OTG_REG_CTRL: begin
                    next_s.rdata = {6'h00, s.ctrl};
                end
                `OTG_REG_IRQ_EN: begin
                    next_s.rdata = {6'h00, s.irq_en};
                end
                `OTG_REG_STATUS: begin
                    next_s.rdata = {1'b0, s.sense_q.charger_ovp, s.sw,
                                    2'h0, s.status};
                end
                `OTG_REG_BOOST_CODE: begin
                    next_s.rdata = s.boost_code;
                end
                default: begin
                    // Unmapped addresses read zero
                    for (int i = 0; i < 3; i++) begin
                        if (reg_addr == `OTG_REG_BUCK_CODE0 + 8'(i)) begin
                            next_s.rdata = {2'h0, s.buck_code[i]};
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr == `OTG_REG_LDO_CODE0 + 8'(i)) begin
                            next_s.rdata = {2'h0, s.ldo_code[i]};
                        end
                    end
                end
            endcase
        end

        // Target voltages follow the codes one cycle later
        for (int i = 0; i < 3; i++) begin
            next_s.buck_mv[i] = dec6(s.buck_code[i]); // R1
        end
        for (int i = 0; i < 4; i++) begin
            next_s.ldo_mv[i] = dec6(s.ldo_code[i]); // R2
        end
        next_s.boost_mv = dec8(s.boost_code); // R3 R4 R5
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
            s.ctrl <= `OTG_RST_CTRL;
            s.irq_en <= `OTG_RST_IRQ_EN;
            s.boost_code <= `OTG_RST_BOOST_CODE;
            s.buck_code <= {3{`OTG_RST_BUCK_CODE}};
            s.ldo_code <= {4{`OTG_RST_LDO_CODE}};
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata = s.rdata;
    assign boost_path_switch = s.sw[0];
    assign input_path_switch = s.sw[1];
    assign irq = |(s.status & s.irq_en); // R9 R14
    assign buck_mv = s.buck_mv;
    assign ldo_mv = s.ldo_mv;
    assign boost_mv = s.boost_mv;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_switch_exclusive: assert property ( // R10
        !(boost_path_switch && input_path_switch))
        else $error("both VBUS switches on");
    a_ovp_cutoff: assert property ( // R13
        s.sense_q.charger_ovp |=> !input_path_switch)
        else $error("input switch on during over-voltage");
    a_trip_boost_off: assert property ( // R7
        trip[0] |=> !boost_path_switch && s.status[0] ##1
        (!boost_path_switch || $past(rise[0])))
        else $error("boost switch stayed on after trip");
    a_trip_input_off: assert property ( // R11
        trip[1] |=> !input_path_switch && s.status[1])
        else $error("input switch stayed on after trip");
    a_rearm_boost: assert property ( // R8
        s.lock[0] && !rise[0] |=> !boost_path_switch)
        else $error("boost switch on without re-arm");
    a_rearm_input: assert property ( // R12
        s.lock[1] && !rise[1] |=> !input_path_switch)
        else $error("input switch on without re-arm");
    a_on_bit_off: assert property ( // R6
        ctrl_wr && !reg_wdata[0] |=> !boost_path_switch)
        else $error("boost switch on with its bit clear");
    a_on_bit_on: assert property ( // R6
        ctrl_wr && reg_wdata[0] && !s.lock[0] && !trip[0]
        |=> boost_path_switch)
        else $error("boost switch failed to close");
    a_irq_boost_gate: assert property ( // R9
        s.status == 2'h1 |-> irq == s.irq_en[0])
        else $error("boost fault interrupt gating wrong");
    a_irq_input_gate: assert property ( // R14
        s.status == 2'h2 |-> irq == s.irq_en[1])
        else $error("input fault interrupt gating wrong");
    a_buck_top: assert property ( // R1
        reg_wr && reg_addr == `OTG_REG_BUCK_CODE0 && reg_wdata[5:0] == 6'h3f
        ##1 !reg_wr |=> buck_mv[0] == 12'hf3c)
        else $error("step-down top code not 3.900 V");
    a_ldo_zero: assert property ( // R2
        s.ldo_code[3] == 6'h00 |=> ldo_mv[3] == 12'h258)
        else $error("linear code zero not 0.600 V");
    a_boost_floor: assert property ( // R3
        s.boost_code[7:6] == 2'h0 |=> boost_mv == 16'h0bb8)
        else $error("low step-up range not 3.000 V");
    a_boost_mid: assert property ( // R4
        s.boost_code == 8'h54 |=> boost_mv == 16'h1388)
        else $error("step-up code not 5.000 V");
    a_boost_sat: assert property ( // R5
        s.boost_code[7:5] == 3'h7 && s.boost_code[4:3] == 2'h3
        |=> boost_mv == 16'ha1b8)
        else $error("step-up ceiling not 41.400 V");
endmodule

// [otg_load_model.sv]
/*
 * Analog side of the VBUS switches: turns the bench's load and
 * over-voltage requests into the three detector levels.
 * Assumes the switch drives come from the block under test.
 */
`timescale 1ns/1ps

module otg_load_model (
    input wire logic boost_path_switch, // Boost switch drive
    input wire logic input_path_switch, // Input switch drive
    input wire logic boost_load, // Overload asked on boost path
    input wire logic input_load, // Overload asked on input path
    input wire logic ovp_high, // Charger input above 6 V
    output otg_pkg::otg_sense_s sense // Detector levels
);
    import otg_pkg::*;
    // ==========================================================
    // Detectors
    // ==========================================================
    // Current can only exceed the limit through a closed switch,
    // so a trip removes the overload by itself
    assign sense.boost_oc = boost_path_switch & boost_load;
    assign sense.input_oc = input_path_switch & input_load;
    // Over-voltage is a property of the source, not of the switch
    assign sense.charger_ovp = ovp_high;
endmodule

// [tb.sv]
/*
 * Self-checking bench of the VBUS switch and voltage-code block.
 * Assumes otg_switch_ctrl, otg_pkg and the load model are compiled.
 */
`timescale 1ns/1ps
`include "otg_map.svh"

module tb;
    import otg_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam int MS = 4; // Short millisecond keeps the run brief
    logic sys_clk, srst, reg_wr, reg_rd; // Clock, reset, strobes
    logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port
    logic boost_path_switch, input_path_switch, irq; // Outputs
    logic boost_load, input_load, ovp_high; // Load requests
    otg_sense_s sense; // Detector levels
    otg_buck_mv_t buck_mv; // Step-down targets
    otg_ldo_mv_t ldo_mv; // Linear targets
    logic [15:0] boost_mv, got; // Step-up target, scratch
    int errors, check_count; // Tallies

    otg_switch_ctrl #(.MS_CYCLES(MS)) i_dut (.sys_clk(sys_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sense(sense), .boost_path_switch(boost_path_switch),
        .input_path_switch(input_path_switch), .irq(irq),
        .buck_mv(buck_mv), .ldo_mv(ldo_mv), .boost_mv(boost_mv));

    otg_load_model i_load (.boost_path_switch(boost_path_switch),
        .input_path_switch(input_path_switch), .boost_load(boost_load),
        .input_load(input_load), .ovp_high(ovp_high), .sense(sense));

    // Free-running 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Expected decode, worked out from the code tables
    // ==========================================================
    function automatic logic [15:0] mv6(input logic [5:0] c);
        int r;
        r = c[5:3];
        if (r < 3) return 16'(600 + 200 * r + 25 * c[2:0]);
        if (r < 6) return 16'(1200 + 400 * (r - 3) + 50 * c[2:0]);
        return 16'(2400 + 800 * (r - 6) + 100 * c[2:0]);
    endfunction
    function automatic logic [15:0] mv8(input logic [7:0] c);
        int s;
        s = c[4:0];
        case (c[7:5])
            3'h2: return 16'(3000 + 100 * s);
            3'h3: return 16'(6200 + 100 * s);
            3'h4: return 16'(9400 + 100 * s);
            3'h5: return 16'(12600 + 200 * s);
            3'h6: return 16'(19000 + 400 * s);
            3'h7: return (s >= 24) ? 16'(41400) : 16'(31800 + 400 * s);
            default: return 16'(3000);
        endcase
    endfunction

    // ==========================================================
    // Access tasks
    // ==========================================================
    // Wait n edges, then step clear of the edge before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string n, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string n, input logic [7:0] a, e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, {8'h00, e}, {8'h00, reg_rdata});
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cut a hang short well beyond the expected run
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        boost_load = 1'b0;
        input_load = 1'b0;
        ovp_high = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        cyc(2);
        // Reset state and an unmapped place
        rchk("ctrl", `OTG_REG_CTRL, 8'h00);
        rchk("irq_en", `OTG_REG_IRQ_EN, 8'h00);
        rchk("status", `OTG_REG_STATUS, 8'h00);
        rchk("boost code", `OTG_REG_BOOST_CODE, 8'h54);
        rchk("unmapped", 8'h20, 8'h00);
        chk("boost_mv reset", 16'd5000, boost_mv);
        chk("buck_mv reset", 16'd1200, 16'(buck_mv[0]));
        // Every step-up code
        for (int c = 0; c < 256; c++) begin
            wr_reg(`OTG_REG_BOOST_CODE, 8'(c));
            cyc(2);
            chk("boost_mv", mv8(8'(c)), boost_mv);
        end
        // Every six-bit code on all step-down and linear channels
        for (int r = 0; r < 7; r++) begin
            for (int c = 0; c < 64; c++) begin
                wr_reg(8'(`OTG_REG_BUCK_CODE0 + r), 8'(c));
                cyc(2);
                got = (r < 3) ? 16'(buck_mv[r]) : 16'(ldo_mv[r - 3]);
                chk("six-bit mv", mv6(6'(c)), got);
            end
        end
        // Switch control and mutual exclusion
        wr_reg(`OTG_REG_CTRL, 8'h01);
        cyc(1);
        chk("boost on", 16'h1, 16'(boost_path_switch));
        wr_reg(`OTG_REG_CTRL, 8'h03);
        cyc(2);
        chk("input held", 16'h0, 16'(input_path_switch));
        wr_reg(`OTG_REG_CTRL, 8'h02);
        cyc(2);
        chk("boost off", 16'h0, 16'(boost_path_switch));
        chk("input on", 16'h1, 16'(input_path_switch));
        // Charger over-voltage
        ovp_high <= 1'b1;
        cyc(3);
        chk("ovp off", 16'h0, 16'(input_path_switch));
        rchk("status ovp", `OTG_REG_STATUS, 8'h40);
        ovp_high <= 1'b0;
        cyc(4);
        chk("ovp gone", 16'h1, 16'(input_path_switch));
        // Broken overload never trips
        input_load <= 1'b1;
        cyc(200 * MS);
        input_load <= 1'b0;
        cyc(2);
        input_load <= 1'b1;
        cyc(200 * MS);
        chk("timer restart", 16'h1, 16'(input_path_switch));
        input_load <= 1'b0;
        cyc(4);
        // Input overload with its interrupt masked
        input_load <= 1'b1;
        cyc(256 * MS + 3);
        chk("input early", 16'h1, 16'(input_path_switch));
        cyc(MS + 1);
        chk("input trip", 16'h0, 16'(input_path_switch));
        chk("irq masked", 16'h0, 16'(irq));
        input_load <= 1'b0;
        rchk("status input", `OTG_REG_STATUS, 8'h02);
        wr_reg(`OTG_REG_IRQ_EN, 8'h02);
        cyc(1);
        chk("irq input", 16'h1, 16'(irq));
        wr_reg(`OTG_REG_CTRL, 8'h02);
        cyc(2);
        chk("no rearm", 16'h0, 16'(input_path_switch));
        wr_reg(`OTG_REG_STATUS, 8'h02);
        cyc(1);
        chk("irq cleared", 16'h0, 16'(irq));
        wr_reg(`OTG_REG_CTRL, 8'h00);
        wr_reg(`OTG_REG_CTRL, 8'h02);
        cyc(2);
        chk("input rearm", 16'h1, 16'(input_path_switch));
        rchk("sw in", `OTG_REG_STATUS, 8'h20);
        // Boost overload with its interrupt enabled
        wr_reg(`OTG_REG_IRQ_EN, 8'h01);
        wr_reg(`OTG_REG_CTRL, 8'h01);
        boost_load <= 1'b1;
        cyc(259 * MS + 4);
        chk("boost trip", 16'h0, 16'(boost_path_switch));
        chk("irq boost", 16'h1, 16'(irq));
        boost_load <= 1'b0;
        rchk("status boost", `OTG_REG_STATUS, 8'h01);
        wr_reg(`OTG_REG_IRQ_EN, 8'h00);
        cyc(1);
        chk("irq boost mask", 16'h0, 16'(irq));
        wr_reg(`OTG_REG_CTRL, 8'h00);
        wr_reg(`OTG_REG_CTRL, 8'h01);
        cyc(2);
        chk("boost rearm", 16'h1, 16'(boost_path_switch));
        rchk("sw boost", `OTG_REG_STATUS, 8'h11);
        give_verdict();
    end
endmodule
